// File: atf_core.sv
// How it works
// R01: Nonzero lead field times precharge; zero skips
// R02: Nonzero share field times acquisition phase
// R03: Share zero gives 8192; both zero skip
// R04: Load field drives extra picofarads directly
// R05: Threshold check fires when tally meets threshold
// R06: Tally and threshold used in repeat modes
// R07: Tally counts triggers; software access; resets zero
// R08: Summing modes: filter is sum shifted right
// R09: Lowpass mode: filter shows lowpass result
// R10: Filter output is signed, read only
// R11: Lead time has high and low byte views
// R12: Share time has byte views, upper unimplemented
// R13: Outcome is read-write, zero reset, byte views
// R14: Previous captures filter or outcome at start
// R15: Precharge runs first, acquisition second
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`include "atf_cfg.svh"

module atf_core #(
    parameter int SUM_W = 18,
    parameter int SHIFT_W = 3
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic conv_trigger,
    input wire logic converter_rc_clock,
    input wire logic conv_done,
    input wire logic [15:0] conv_data,
    input wire logic [SUM_W-1:0] sum_register,
    input wire logic [15:0] lowpass_result,
    output logic precharge_on,
    output logic acquire_on,
    output logic conv_start,
    output logic [4:0] extra_sampling_load,
    output logic thresh_check,
    output logic busy
);
    import atf_pkg::*;

    // Filter slice needs 16 bits; the shift field must fit mode bits 7:4
    if (SUM_W < 16 || SHIFT_W < 1 || SHIFT_W > 4) begin : g_bad_cfg
        $error("atf_core: unsupported SUM_W or SHIFT_W");
    end

    typedef struct packed {
        logic [2:0][2:0] sync;
        logic [2:0] lvl;
        atf_state_t state;
        logic [13:0] ctr;
        logic go;
        logic clk_sel;
        logic prev_pick;
        atf_mode_t mode;
        logic [SHIFT_W-1:0] shift_amount;
        logic [12:0] lead_time;
        logic [12:0] share_time;
        logic [4:0] extra_load;
        logic [7:0] repeat_threshold;
        logic [7:0] trigger_tally;
        logic [15:0] outcome;
        logic [15:0] prev_outcome;
        logic [15:0] filter_output;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic lead_on;
        logic share_on;
        logic conv_start;
        logic thresh_check;
    } atf_core_state_t;

    atf_core_state_t st_q;
    atf_core_state_t st_d;

    logic [2:0] pins;
    logic [2:0] rise;
    logic [9:0] idx;
    logic addr_ok;
    logic hit;
    logic [7:0] rd_byte;
    logic xfer;
    logic tick;
    logic repeat_mode;
    logic [7:0] tally_next;
    logic [SUM_W-1:0] shifted;

    assign pins = {conv_done, converter_rc_clock, conv_trigger};
    assign idx = paddr[11:2];
    assign addr_ok = (paddr[1:0] == 2'h0);

    always_comb begin
        st_d = st_q;
        st_d.conv_start = 1'b0;
        st_d.thresh_check = 1'b0;
        rise = 3'h0;
        hit = 1'b0;
        rd_byte = 8'h00;
        xfer = 1'b0;
        tick = 1'b0;
        repeat_mode = 1'b0;
        tally_next = 8'h00;
        shifted = '0;

        // Three-stage pin sampling; a level counts once stages two and
        // three agree, so a glitch on the pin cannot start a phase
        for (int i = 0; i < 3; i++) begin
            st_d.sync[i] = {st_q.sync[i][1:0], pins[i]};
            if (st_q.sync[i][1] == st_q.sync[i][2] &&
                st_q.sync[i][2] != st_q.lvl[i]) begin
                st_d.lvl[i] = st_q.sync[i][2];
                rise[i] = st_q.sync[i][2];
            end
        end

        // Register read decode
        unique case (idx)
            `ATF_IDX_FILTER_L: begin
                hit = 1'b1;
                rd_byte = st_q.filter_output[7:0]; // see R10
            end
            `ATF_IDX_FILTER_H: begin
                hit = 1'b1;
                rd_byte = st_q.filter_output[15:8]; // see R10
            end
            `ATF_IDX_TALLY: begin
                hit = 1'b1;
                rd_byte = st_q.trigger_tally; // see R07
            end
            `ATF_IDX_THRESH: begin
                hit = 1'b1;
                rd_byte = st_q.repeat_threshold;
            end
            `ATF_IDX_PREV_L: begin
                hit = 1'b1;
                rd_byte = st_q.prev_outcome[7:0];
            end
            `ATF_IDX_PREV_H: begin
                hit = 1'b1;
                rd_byte = st_q.prev_outcome[15:8];
            end
            `ATF_IDX_OUTCOME_L: begin
                hit = 1'b1;
                rd_byte = st_q.outcome[7:0]; // see R13
            end
            `ATF_IDX_OUTCOME_H: begin
                hit = 1'b1;
                rd_byte = st_q.outcome[15:8]; // see R13
            end
            `ATF_IDX_SHARE_L: begin
                hit = 1'b1;
                rd_byte = st_q.share_time[7:0]; // see R12
            end
            `ATF_IDX_SHARE_H: begin
                hit = 1'b1;
                rd_byte = {3'h0, st_q.share_time[12:8]}; // see R12
            end
            `ATF_IDX_LOAD: begin
                hit = 1'b1;
                rd_byte = {3'h0, st_q.extra_load};
            end
            `ATF_IDX_LEAD_L: begin
                hit = 1'b1;
                rd_byte = st_q.lead_time[7:0]; // see R11
            end
            `ATF_IDX_LEAD_H: begin
                hit = 1'b1;
                rd_byte = {3'h0, st_q.lead_time[12:8]}; // see R11
            end
            `ATF_IDX_CTRL: begin
                hit = 1'b1;
                rd_byte = {5'h00, st_q.prev_pick, st_q.clk_sel, st_q.go};
            end
            `ATF_IDX_MODE: begin
                hit = 1'b1;
                rd_byte = 8'((SHIFT_W + 4)'(st_q.shift_amount) << 4) |
                          {5'h00, st_q.mode};
            end
            `ATF_IDX_STATUS: begin
                hit = 1'b1;
                rd_byte = {5'h00, st_q.state != ATF_ST_IDLE, st_q.state};
            end
            default: begin
                hit = 1'b0;
                rd_byte = 8'h00;
            end
        endcase

        // APB: answer is prepared in setup so access completes at once
        st_d.pready = psel & ~penable;
        // Error stands only with ready, never into the idle cycles after
        st_d.pslverr = 1'b0;
        if (psel && !penable) begin
            st_d.pslverr = ~(hit & addr_ok);
            st_d.prdata = (hit && addr_ok && !pwrite) ?
                          {24'h000000, rd_byte} : 32'h00000000;
        end
        // A write lands only in the access cycle that the slave answers
        xfer = psel & penable & st_q.pready;

        // Software writes first; hardware events below win a collision
        if (xfer && pwrite && hit && addr_ok) begin
            unique case (idx)
                `ATF_IDX_TALLY: st_d.trigger_tally = pwdata[7:0]; // see R07
                `ATF_IDX_THRESH: st_d.repeat_threshold = pwdata[7:0];
                `ATF_IDX_OUTCOME_L: st_d.outcome[7:0] = pwdata[7:0]; // see R13
                `ATF_IDX_OUTCOME_H: st_d.outcome[15:8] = pwdata[7:0]; // see R13
                `ATF_IDX_SHARE_L: st_d.share_time[7:0] = pwdata[7:0]; // see R12
                `ATF_IDX_SHARE_H: st_d.share_time[12:8] = pwdata[4:0]; // see R12
                `ATF_IDX_LOAD: st_d.extra_load = pwdata[4:0]; // see R04
                `ATF_IDX_LEAD_L: st_d.lead_time[7:0] = pwdata[7:0]; // see R11
                `ATF_IDX_LEAD_H: st_d.lead_time[12:8] = pwdata[4:0]; // see R11
                `ATF_IDX_CTRL: begin
                    st_d.go = pwdata[`ATF_CTRL_GO];
                    st_d.clk_sel = pwdata[`ATF_CTRL_CLK_SEL];
                    st_d.prev_pick = pwdata[`ATF_CTRL_PREV_PICK];
                end
                `ATF_IDX_MODE: begin
                    st_d.mode = atf_mode_t'(pwdata[`ATF_MODE_LSB +: 3]);
                    st_d.shift_amount = pwdata[`ATF_SHIFT_LSB +: SHIFT_W];
                end
                default: begin
                    st_d.go = st_d.go;
                end
            endcase
        end

        // Phase timing ticks on the system clock or on the RC clock edge
        // RC edges pass the pin filter, so that clock must stay slow
        tick = st_q.clk_sel ? rise[`ATF_PIN_RC] : 1'b1; // see R01 R02
        repeat_mode = (st_q.mode == ATF_MD_LOWPASS) ||
                      (st_q.mode == ATF_MD_BURST) ||
                      (st_q.mode == ATF_MD_AVERAGE); // see R06

        unique case (st_q.state)
            ATF_ST_IDLE: begin
                if (st_q.go || rise[`ATF_PIN_TRIG]) begin
                    st_d.go = 1'b1;
                    // see R14
                    // Taken from the old registers, before this conversion
                    st_d.prev_outcome = st_q.prev_pick ?
                                        st_q.filter_output : st_q.outcome;
                    if (st_q.lead_time != `ATF_RST_TIME) begin
                        st_d.state = ATF_ST_LEAD; // see R15
                        st_d.ctr = {1'b0, st_q.lead_time}; // see R01
                    end else if (st_q.share_time != `ATF_RST_TIME) begin
                        st_d.state = ATF_ST_SHARE; // see R01
                        st_d.ctr = {1'b0, st_q.share_time}; // see R02
                    end else begin
                        st_d.state = ATF_ST_CONV; // see R03
                        st_d.conv_start = 1'b1;
                    end
                end
            end
            ATF_ST_LEAD: begin
                if (tick) begin
                    if (st_q.ctr == `ATF_CTR_ONE) begin
                        st_d.state = ATF_ST_SHARE; // see R15
                        // Lead is nonzero here, so zero share means 8192
                        st_d.ctr = (st_q.share_time == `ATF_RST_TIME) ?
                                   `ATF_SHARE_ZERO_LEN :
                                   {1'b0, st_q.share_time}; // see R03
                    end else begin
                        st_d.ctr = st_q.ctr - `ATF_CTR_ONE; // see R01
                    end
                end
            end
            ATF_ST_SHARE: begin
                if (tick) begin
                    if (st_q.ctr == `ATF_CTR_ONE) begin
                        st_d.state = ATF_ST_CONV;
                        st_d.conv_start = 1'b1;
                    end else begin
                        st_d.ctr = st_q.ctr - `ATF_CTR_ONE; // see R02
                    end
                end
            end
            ATF_ST_CONV: begin
                // conv_data must already be stable when the filtered edge lands
                if (rise[`ATF_PIN_DONE]) begin
                    st_d.state = ATF_ST_IDLE;
                    st_d.go = 1'b0;
                    st_d.outcome = conv_data; // see R13
                    if (repeat_mode) begin
                        // Tally saturates rather than wraps past full scale
                        tally_next = (st_d.trigger_tally == 8'hFF) ?
                                     8'hFF : st_d.trigger_tally + 8'h01;
                        if (tally_next == st_q.repeat_threshold) begin
                            st_d.thresh_check = 1'b1; // see R05
                            st_d.trigger_tally = 8'h00;
                        end else begin
                            st_d.trigger_tally = tally_next; // see R07
                        end
                    end else begin
                        st_d.thresh_check = 1'b1; // see R06
                    end
                end
            end
        endcase

        // Filter output tracks the summing or lowpass source every cycle
        shifted = $signed(sum_register) >>> st_q.shift_amount;
        unique case (st_q.mode)
            ATF_MD_ACCUMULATE,
            ATF_MD_AVERAGE,
            ATF_MD_BURST: st_d.filter_output = shifted[15:0]; // see R08
            ATF_MD_LOWPASS: st_d.filter_output = lowpass_result; // see R09
            // Basic mode holds the last value rather than clearing it
            default: st_d.filter_output = st_q.filter_output;
        endcase

        st_d.lead_on = (st_d.state == ATF_ST_LEAD);
        st_d.share_on = (st_d.state == ATF_ST_SHARE);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            // Filter and previous clear too, for a known start
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pready = st_q.pready;
    assign prdata = st_q.prdata;
    assign pslverr = st_q.pslverr;
    assign precharge_on = st_q.lead_on;
    assign acquire_on = st_q.share_on;
    assign conv_start = st_q.conv_start;
    assign extra_sampling_load = st_q.extra_load; // see R04
    assign thresh_check = st_q.thresh_check;
    assign busy = st_q.go;

endmodule : atf_core

// File: atf_cfg.svh
`ifndef ATF_CFG_SVH
`define ATF_CFG_SVH

// Register indices; byte address on the bus is four times the index
`define ATF_IDX_FILTER_L 10'h3E1
`define ATF_IDX_FILTER_H 10'h3E2
`define ATF_IDX_TALLY 10'h3E6
`define ATF_IDX_THRESH 10'h3E7
`define ATF_IDX_PREV_L 10'h3E8
`define ATF_IDX_PREV_H 10'h3E9
`define ATF_IDX_OUTCOME_L 10'h3EA
`define ATF_IDX_OUTCOME_H 10'h3EB
`define ATF_IDX_SHARE_L 10'h3EE
`define ATF_IDX_SHARE_H 10'h3EF
`define ATF_IDX_LOAD 10'h3F0
`define ATF_IDX_LEAD_L 10'h3F1
`define ATF_IDX_LEAD_H 10'h3F2
`define ATF_IDX_CTRL 10'h3F4
`define ATF_IDX_MODE 10'h3F5
`define ATF_IDX_STATUS 10'h3F6

// Control register fields
`define ATF_CTRL_GO 0
`define ATF_CTRL_CLK_SEL 1
`define ATF_CTRL_PREV_PICK 2
// Mode register fields
`define ATF_MODE_LSB 0
`define ATF_SHIFT_LSB 4

// Reset values
`define ATF_RST_BYTE 8'h00
`define ATF_RST_WORD 16'h0000
`define ATF_RST_TIME 13'h0000

// Acquisition length when its field is zero but precharge is not
`define ATF_SHARE_ZERO_LEN 14'h2000
`define ATF_CTR_ONE 14'h0001

// Synchroniser lane numbers
`define ATF_PIN_TRIG 0
`define ATF_PIN_RC 1
`define ATF_PIN_DONE 2

`endif

// File: atf_pkg.sv
package atf_pkg;

    typedef enum logic [1:0] {
        ATF_ST_IDLE = 2'b00,
        ATF_ST_LEAD = 2'b01,
        ATF_ST_SHARE = 2'b10,
        ATF_ST_CONV = 2'b11
    } atf_state_t;

    typedef enum logic [2:0] {
        ATF_MD_BASIC = 3'b000,
        ATF_MD_ACCUMULATE = 3'b001,
        ATF_MD_AVERAGE = 3'b010,
        ATF_MD_BURST = 3'b011,
        ATF_MD_LOWPASS = 3'b100
    } atf_mode_t;

endpackage : atf_pkg

// File: atf_core_props.sv
`timescale 1ns/100ps
module atf_core_props (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic precharge_on,
    input wire logic acquire_on,
    input wire logic conv_start,
    input wire logic thresh_check,
    input wire logic busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    rdy_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    rdy_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_with_rdy_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    phase_apart_a: assert property (!(precharge_on && acquire_on))
        else $error("phases overlap");
    lead_to_share_a: assert property ($fell(precharge_on) |-> acquire_on)
        else $error("acquisition not after precharge");
    share_to_start_a: assert property ($fell(acquire_on) |-> conv_start)
        else $error("start missing after acquisition");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    check_pulse_a: assert property (thresh_check |=> !thresh_check)
        else $error("check pulse too long");
    phase_busy_a: assert property (precharge_on || acquire_on || conv_start |-> busy)
        else $error("phase while idle");
    cover property (conv_start);
    cover property (thresh_check);
    cover property (pslverr);
endmodule : atf_core_props

bind atf_core atf_core_props i_props (.ref_clk(ref_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .precharge_on(precharge_on), .acquire_on(acquire_on),
    .conv_start(conv_start), .thresh_check(thresh_check), .busy(busy));

// File: tb_adc_timing_repeat_filter_regs.sv
`timescale 1ns/100ps
`include "atf_cfg.svh"
`define CHK(n, x, a) begin comparisons++; if ((a) !== (x)) begin num_errors++; \
    $display("ERROR %s exp %0h got %0h", n, x, a); end end
module tb_adc_timing_repeat_filter_regs;
    logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic conv_trigger = 0, converter_rc_clock = 0, conv_done = 0;
    logic [15:0] conv_data = 0, lowpass_result = 0;
    logic [17:0] sum_register = 0;
    wire pready, pslverr, precharge_on, acquire_on, conv_start, thresh_check, busy;
    wire [31:0] prdata;
    wire [4:0] extra_sampling_load;
    int num_errors = 0, comparisons = 0, n_pre = 0, n_acq = 0, n_st = 0, n_chk = 0;
    logic [31:0] seed = 32'h00018326;
    logic [2:0] rc_div = 0;
    atf_core i_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .conv_trigger(conv_trigger), .converter_rc_clock(converter_rc_clock),
        .conv_done(conv_done), .conv_data(conv_data),
        .sum_register(sum_register), .lowpass_result(lowpass_result),
        .precharge_on(precharge_on), .acquire_on(acquire_on),
        .conv_start(conv_start), .extra_sampling_load(extra_sampling_load),
        .thresh_check(thresh_check), .busy(busy));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // Counters lag one edge, so snapshots taken after an edge stay consistent
    always @(posedge ref_clk) begin
        n_pre <= n_pre + (precharge_on === 1'b1);
        n_acq <= n_acq + (acquire_on === 1'b1);
        n_st <= n_st + (conv_start === 1'b1);
        n_chk <= n_chk + (thresh_check === 1'b1);
        // Free-running RC clock, eight system clocks a period
        rc_div <= rc_div + 3'h1;
        converter_rc_clock <= rc_div[2];
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task report_and_stop;
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    task apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
             output logic [7:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            report_and_stop;
        end
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task rd(input logic [9:0] idx, input logic [7:0] x, input logic err);
        logic [7:0] q;
        logic e;
        apb(1'b0, idx, 8'h00, q, e);
        `CHK("rdata", x, q)
        `CHK("slverr", err, e)
    endtask : rd
    logic [9:0] rl[8] = '{`ATF_IDX_TALLY, `ATF_IDX_THRESH, `ATF_IDX_OUTCOME_L,
        `ATF_IDX_OUTCOME_H, `ATF_IDX_SHARE_L, `ATF_IDX_SHARE_H,
        `ATF_IDX_LEAD_L, `ATF_IDX_LEAD_H};
    logic [7:0] ml[8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F,
        8'hFF, 8'h1F};
    logic [12:0] lt[4] = '{13'h0002, 13'h0000, 13'h0001, 13'h0000};
    logic [12:0] st[4] = '{13'h0001, 13'h0003, 13'h0000, 13'h0000};
    logic [7:0] q, r8;
    logic [12:0] ld, sh;
    logic [15:0] x_out, x_flt, x_prv, dat, lp;
    logic [17:0] sr;
    logic [2:0] md, cs;
    logic e, c, ks;
    int n, p0, a0, s0, c0, x_tal, x_acq;
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        foreach (rl[i]) rd(rl[i], 8'h00, 1'b0);
        rd(10'h3E0, 8'h00, 1'b1);
        apb(1'b1, `ATF_IDX_FILTER_L, 8'hA5, q, e);
        rd(`ATF_IDX_FILTER_L, 8'h00, 1'b0);
        foreach (rl[i]) begin
            r8 = 8'(rnd());
            apb(1'b1, rl[i], r8, q, e);
            rd(rl[i], r8 & ml[i], 1'b0);
        end
        r8 = 8'(rnd());
        apb(1'b1, `ATF_IDX_LOAD, r8, q, e);
        `CHK("load", r8[4:0], extra_sampling_load)
        apb(1'b1, `ATF_IDX_OUTCOME_L, 8'h00, q, e);
        apb(1'b1, `ATF_IDX_OUTCOME_H, 8'h00, q, e);
        apb(1'b1, `ATF_IDX_TALLY, 8'h00, q, e);
        apb(1'b1, `ATF_IDX_THRESH, 8'h02, q, e);
        {x_out, x_flt, x_tal} = 0;
        for (int i = 0; i < 8; i++) begin
            ld = (i < 4) ? lt[i] : 13'(rnd() % 40 + 1);
            sh = (i < 4) ? st[i] : 13'(rnd() % 40 + 1);
            md = 3'(i % 5);
            cs = 3'(rnd());
            sr = 18'(rnd());
            lp = 16'(rnd());
            dat = 16'(rnd());
            apb(1'b1, `ATF_IDX_LEAD_L, ld[7:0], q, e);
            apb(1'b1, `ATF_IDX_LEAD_H, {3'h0, ld[12:8]}, q, e);
            apb(1'b1, `ATF_IDX_SHARE_L, sh[7:0], q, e);
            apb(1'b1, `ATF_IDX_SHARE_H, {3'h0, sh[12:8]}, q, e);
            apb(1'b1, `ATF_IDX_MODE, {1'b0, cs, 1'b0, md}, q, e);
            // Sources change only after the mode is set, so basic mode holds
            sum_register <= sr;
            lowpass_result <= lp;
            if (md inside {3'h1, 3'h2, 3'h3})
                x_flt = 16'($signed(sr) >>> cs);
            else if (md == 3'h4) x_flt = lp;
            ks = (i >= 6);
            x_acq = (sh != 0) ? sh : ((ld != 0) ? 8192 : 0);
            x_prv = i[0] ? x_flt : x_out;
            {p0, a0, s0, c0} = {n_pre, n_acq, n_st, n_chk};
            apb(1'b1, `ATF_IDX_CTRL, {5'h00, i[0], ks, i != 5}, q, e);
            if (i == 5) conv_trigger <= 1'b1;
            n = 0;
            while (n_st == s0 && n < 9000) begin
                @(posedge ref_clk);
                n++;
            end
            conv_trigger <= 1'b0;
            conv_data <= dat;
            conv_done <= 1'b1;
            n = 0;
            while (busy !== 1'b0 && n < 40) begin
                @(posedge ref_clk);
                n++;
            end
            conv_done <= 1'b0;
            @(posedge ref_clk);
            if (n_st == s0 || busy !== 1'b0) begin
                num_errors++;
                report_and_stop;
            end
            x_out = dat;
            c = 1'b1;
            if (md >= 3'h2) begin
                x_tal++;
                c = (x_tal == 2);
                if (c) x_tal = 0;
            end
            rd(`ATF_IDX_OUTCOME_L, x_out[7:0], 1'b0);
            rd(`ATF_IDX_OUTCOME_H, x_out[15:8], 1'b0);
            rd(`ATF_IDX_FILTER_L, x_flt[7:0], 1'b0);
            rd(`ATF_IDX_FILTER_H, x_flt[15:8], 1'b0);
            rd(`ATF_IDX_PREV_L, x_prv[7:0], 1'b0);
            rd(`ATF_IDX_PREV_H, x_prv[15:8], 1'b0);
            rd(`ATF_IDX_TALLY, 8'(x_tal), 1'b0);
            // With the RC clock a phase spans one RC period per count, the first one can be partial
            n = ks ? 8 : 1;
            `CHK("pre", int'(ld), (n_pre - p0 + n - 1) / n)
            `CHK("acq", x_acq, (n_acq - a0 + n - 1) / n)
            `CHK("start", 1, n_st - s0)
            `CHK("check", int'(c), n_chk - c0)
        end
        report_and_stop;
    end
endmodule : tb_adc_timing_repeat_filter_regs
